// ### vca_pkg.sv
// Package of constants for the oscillator calibration assist block
// How it works
// - Calibration searches band and amplitude; core comes from the start estimate except in start-from-current, which keeps the active core
// - Partial assist starts search from software estimates
// - Start-from-current seeds search with active values
// - All three overrides apply written values
// - Fully forced skips calibration, values held
// - Completed calibration results are readable
package vca_pkg;
  localparam int          VCA_CORE_W      = 3;
  localparam int          VCA_BAND_W      = 8;
  localparam int          VCA_AMP_W       = 9;
  localparam int          VCA_NUM_CORES   = 6;
  localparam logic [11:0] VCA_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] VCA_ADDR_START  = 12'h004;
  localparam logic [11:0] VCA_ADDR_FORCE  = 12'h008;
  localparam logic [11:0] VCA_ADDR_STATUS = 12'h00C;
  localparam logic [11:0] VCA_ADDR_RESULT = 12'h010;
  localparam int          VCA_CTRL_TRIG   = 0;
  localparam int          VCA_CTRL_QUICK  = 1;
  localparam int          VCA_CTRL_OCORE  = 2;
  localparam int          VCA_CTRL_OBAND  = 3;
  localparam int          VCA_CTRL_OAMP   = 4;
  localparam int          VCA_FLD_CORE    = 0;
  localparam int          VCA_FLD_BAND    = 8;
  localparam int          VCA_FLD_AMP     = 16;
  localparam int          VCA_STAT_BUSY   = 0;
  localparam int          VCA_STAT_DONE   = 1;
  localparam logic [1:0]  VCA_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  VCA_RESP_SLVERR = 2'h2;
  localparam logic [2:0]  VCA_CORE_RST    = 3'h1;
  localparam logic [7:0]  VCA_BAND_RST    = 8'h80;
  localparam logic [8:0]  VCA_AMP_RST     = 9'h080;
  localparam int          VCA_SETTLE_CYC  = 4;
  typedef enum logic [1:0] {
    VCA_IDLE   = 2'b00,
    VCA_BAND   = 2'b01,
    VCA_AMP    = 2'b10,
    VCA_FINISH = 2'b11
  } vca_state_t;
endpackage

// ### vca_search.sv
`timescale 1ns/10ps
// Successive approximation search of one setting
module vca_search
  import vca_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] seed,
  input  wire logic         higher,
  // Result
  output logic              busy,
  output logic [W-1:0]      value
);
  logic [W-1:0] step_r;
  logic         busy_r;
  logic [W-1:0] value_r;

  assign busy  = busy_r;
  assign value = value_r;

  // Halving step from the seed toward the comparator answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_r  <= '0;
      busy_r  <= 1'b0;
      value_r <= '0;
    end else if (start) begin
      value_r <= seed;
      step_r  <= W'(1) << (W - 2);
      busy_r  <= 1'b1;
    end else if (busy_r) begin
      if (higher) begin
        value_r <= (value_r > ~step_r) ? {W{1'b1}} : W'(value_r + step_r);
      end else begin
        value_r <= (value_r < step_r) ? '0 : W'(value_r - step_r);
      end
      step_r <= step_r >> 1;
      busy_r <= (step_r > W'(1));
    end
  end
endmodule

// ### vca_top.sv
`timescale 1ns/10ps
// Oscillator calibration assist with AXI4-Lite registers
module vca_top
  import vca_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // AXI4-Lite write
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Oscillator
  input  wire logic                  freq_high,
  output logic [VCA_CORE_W-1:0]      oscillator_core_select,
  output logic [VCA_BAND_W-1:0]      band_value,
  output logic [VCA_AMP_W-1:0]       amplitude_value,
  output logic                       cal_busy
);
  logic                  aw_hold_r, w_hold_r;
  logic [11:0]           awaddr_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;
  logic                  quick_r, ocore_r, oband_r, oamp_r, done_r;
  logic [VCA_CORE_W-1:0] core_st_r, core_r, res_core_r;
  logic [VCA_BAND_W-1:0] band_st_r, band_r, res_band_r;
  logic [VCA_AMP_W-1:0]  amp_st_r, amp_r, res_amp_r;
  vca_state_t            state_r;
  logic [2:0]            settle_r;
  logic                  trig, all_forced, wr_go;
  logic                  band_start, amp_start, band_busy, amp_busy;
  logic [VCA_BAND_W-1:0] band_seed, band_srch;
  logic [VCA_AMP_W-1:0]  amp_seed, amp_srch;
  logic [31:0]           rd_word;
  logic [31:0]           st_word, st_new;
  logic                  cal_busy_r;

  function automatic logic [7:0] lane(input logic [31:0] d, input logic [3:0] s,
                                      input logic [31:0] o, input int b);
    lane = s[b] ? d[8*b +: 8] : o[8*b +: 8];
  endfunction

  // Write channel capture, either order
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= VCA_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == VCA_ADDR_CTRL || awaddr_r == VCA_ADDR_START ||
                         awaddr_r == VCA_ADDR_FORCE) ? VCA_RESP_OKAY : VCA_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Trigger is a self-clearing write pulse
  assign trig = wr_go && awaddr_r == VCA_ADDR_CTRL && wstrb_r[0] && wdata_r[VCA_CTRL_TRIG];
  // Skip is decided by the overrides carried in the trigger write
  assign all_forced = wdata_r[VCA_CTRL_OCORE] && wdata_r[VCA_CTRL_OBAND] &&
                      wdata_r[VCA_CTRL_OAMP];

  // Start word with written byte lanes merged in
  assign st_word = {7'h00, amp_st_r, band_st_r, 5'h00, core_st_r};
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign st_new[8*g +: 8] = lane(wdata_r, wstrb_r, st_word, g);
  end

  // Software control, start estimates and forced values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      quick_r   <= 1'b0;
      ocore_r   <= 1'b0;
      oband_r   <= 1'b0;
      oamp_r    <= 1'b0;
      core_st_r <= VCA_CORE_RST;
      band_st_r <= VCA_BAND_RST;
      amp_st_r  <= VCA_AMP_RST;
    end else if (wr_go) begin
      case (awaddr_r)
        VCA_ADDR_CTRL: begin
          if (wstrb_r[0]) begin
            quick_r <= wdata_r[VCA_CTRL_QUICK];
            ocore_r <= wdata_r[VCA_CTRL_OCORE];
            oband_r <= wdata_r[VCA_CTRL_OBAND];
            oamp_r  <= wdata_r[VCA_CTRL_OAMP];
          end
        end
        VCA_ADDR_START, VCA_ADDR_FORCE: begin
          core_st_r <= st_new[VCA_FLD_CORE +: VCA_CORE_W];
          band_st_r <= st_new[VCA_FLD_BAND +: VCA_BAND_W];
          amp_st_r  <= st_new[VCA_FLD_AMP +: VCA_AMP_W];
        end
        default: begin
        end
      endcase
    end
  end

  // Search seeds from estimates or active values
  assign band_seed  = quick_r ? band_r : band_st_r;
  assign amp_seed   = quick_r ? amp_r : amp_st_r;
  assign band_start = state_r == VCA_IDLE && trig && !all_forced;
  assign amp_start  = state_r == VCA_BAND && !band_busy && settle_r == 3'h0;

  vca_search #(.W(VCA_BAND_W)) u_band (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (band_start),
    .seed    (band_seed),
    .higher  (freq_high),
    .busy    (band_busy),
    .value   (band_srch)
  );

  vca_search #(.W(VCA_AMP_W)) u_amp (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (amp_start),
    .seed    (amp_seed),
    .higher  (freq_high),
    .busy    (amp_busy),
    .value   (amp_srch)
  );

  // Calibration sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= VCA_IDLE;
      settle_r   <= '0;
      done_r     <= 1'b0;
      cal_busy_r <= 1'b0;
    end else begin
      case (state_r)
        VCA_IDLE: begin
          if (band_start) begin
            state_r  <= VCA_BAND;
            settle_r   <= 3'(VCA_SETTLE_CYC);
            done_r     <= 1'b0;
            cal_busy_r <= 1'b1;
          end
        end
        VCA_BAND: begin
          if (settle_r != 3'h0) begin
            settle_r <= settle_r - 3'h1;
          end else if (!band_busy) begin
            state_r <= VCA_AMP;
          end
        end
        VCA_AMP: begin
          if (!amp_busy) begin
            state_r <= VCA_FINISH;
          end
        end
        VCA_FINISH: begin
          state_r    <= VCA_IDLE;
          done_r     <= 1'b1;
          cal_busy_r <= 1'b0;
        end
        default: begin
          state_r    <= VCA_IDLE;
          cal_busy_r <= 1'b0;
        end
      endcase
    end
  end

  // Active settings: forced, searched, or held
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_r <= VCA_CORE_RST;
      band_r <= VCA_BAND_RST;
      amp_r  <= VCA_AMP_RST;
    end else begin
      // Start-from-current keeps the active core
      if (ocore_r || (band_start && !quick_r)) begin
        core_r <= core_st_r;
      end
      if (oband_r) begin
        band_r <= band_st_r;
      end else if (state_r == VCA_FINISH) begin
        band_r <= band_srch;
      end
      if (oamp_r) begin
        amp_r <= amp_st_r;
      end else if (state_r == VCA_FINISH) begin
        amp_r <= amp_srch;
      end
    end
  end

  // Readable results latched on completion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_core_r <= VCA_CORE_RST;
      res_band_r <= VCA_BAND_RST;
      res_amp_r  <= VCA_AMP_RST;
    end else if (state_r == VCA_FINISH) begin
      res_core_r <= core_r;
      res_band_r <= oband_r ? band_st_r : band_srch;
      res_amp_r  <= oamp_r ? amp_st_r : amp_srch;
    end
  end

  assign oscillator_core_select = core_r;
  assign band_value             = band_r;
  assign amplitude_value        = amp_r;
  assign cal_busy               = cal_busy_r;

  // Read channel
  always_comb begin
    rd_word = '0;
    case (s_axi_araddr)
      VCA_ADDR_CTRL:   rd_word = {27'h0, oamp_r, oband_r, ocore_r, quick_r, 1'b0};
      VCA_ADDR_START,
      VCA_ADDR_FORCE:  rd_word = {7'h00, amp_st_r, band_st_r, 5'h00, core_st_r};
      VCA_ADDR_STATUS: rd_word = {30'h0, done_r, cal_busy_r};
      VCA_ADDR_RESULT: rd_word = {7'h00, res_amp_r, res_band_r, 5'h00, res_core_r};
      default:         rd_word = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= VCA_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (s_axi_araddr <= VCA_ADDR_RESULT && s_axi_araddr[1:0] == 2'b00)
                        ? VCA_RESP_OKAY : VCA_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  sequence band_phase_s;
    state_r == VCA_BAND [*5];
  endsequence

  busy_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cal_busy_r == (state_r != VCA_IDLE))
    else $error("busy flag out of step with sequencer");
  forced_skip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (all_forced && state_r == VCA_IDLE && trig) |=> state_r == VCA_IDLE)
    else $error("forced run started a calibration");
  forced_band_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(oband_r) |-> band_r == $past(band_st_r))
    else $error("forced band not applied");
  done_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == VCA_FINISH |=> done_r && res_band_r == band_r)
    else $error("result not latched");
  seq_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    band_start |=> band_phase_s)
    else $error("band phase too short");
  seed_band_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (band_start && !quick_r) |=> band_srch == $past(band_st_r))
    else $error("search not seeded from estimate");
  quick_seed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (band_start && quick_r && !ocore_r) |=> band_srch == $past(band_r) &&
                                            core_r == $past(core_r))
    else $error("search not seeded from active value");
  core_take_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (band_start && !quick_r) |=> core_r == $past(core_st_r))
    else $error("core not taken at start");
  run_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    band_start |-> ##[10:40] done_r)
    else $error("calibration did not finish");
endmodule

// ### vca_top_test.sv
`timescale 1ns/10ps
// Self-checking bench for the oscillator calibration assist block
module vca_top_test
  import vca_pkg::*;
;
  logic        sys_clk;
  logic        rst_n;
  logic [11:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        freq_high;
  logic [2:0]  oscillator_core_select;
  logic [7:0]  band_value;
  logic [8:0]  amplitude_value;
  logic        cal_busy;
  int          n_errors;
  int          num_checks;
  logic [31:0] rd;
  logic [31:0] res1;
  logic [1:0]  rsp;

  vca_top u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .freq_high(freq_high),
    .oscillator_core_select(oscillator_core_select), .band_value(band_value),
    .amplitude_value(amplitude_value), .cal_busy(cal_busy)
  );

  always #12.5 sys_clk = ~sys_clk;

  // Settings in result register layout
  function automatic logic [31:0] pk(input logic [2:0] c, input logic [7:0] b,
                                     input logic [8:0] a);
    return {7'h00, a, b, 5'h00, c};
  endfunction

  function automatic logic [31:0] act();
    return pk(oscillator_core_select, band_value, amplitude_value);
  endfunction

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timed_out();
    n_errors++;
    $display("MISMATCH at %0t: wait ran out", $time);
    give_verdict();
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
      end
      if (k > 100) begin
        timed_out();
      end
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
      end
      if (k > 100) begin
        timed_out();
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (cal_busy !== lvl) begin
      @(posedge sys_clk);
      k++;
      if (k > 100) begin
        timed_out();
      end
    end
  endtask

  initial begin
    int i;
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, freq_high} = '0;
    s_axi_wstrb = 4'hF;
    n_errors = 0;
    num_checks = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset state and refused accesses
    chk(act(), pk(VCA_CORE_RST, VCA_BAND_RST, VCA_AMP_RST));
    axi_rd(VCA_ADDR_STATUS, rd, rsp);
    chk(rd, 32'h0);
    axi_rd(12'h020, rd, rsp);
    chk({30'h0, rsp}, {30'h0, VCA_RESP_SLVERR});
    axi_wr(VCA_ADDR_RESULT, 32'h0, rsp);
    chk({30'h0, rsp}, {30'h0, VCA_RESP_SLVERR});
    // Search seeded from software estimates
    axi_wr(VCA_ADDR_START, pk(3'h3, 8'h40, 9'h100), rsp);
    chk({30'h0, rsp}, {30'h0, VCA_RESP_OKAY});
    axi_wr(VCA_ADDR_CTRL, 32'h1, rsp);
    wait_busy(1'b1);
    chk(act(), pk(3'h3, VCA_BAND_RST, VCA_AMP_RST));
    wait_busy(1'b0);
    axi_rd(VCA_ADDR_STATUS, rd, rsp);
    chk(rd, 32'h2);
    axi_rd(VCA_ADDR_RESULT, res1, rsp);
    chk(res1, act());
    chk(res1 & 32'h7, 32'h3);
    chk({30'h0, res1[15:8] < 8'h40, res1[24:16] < 9'h100}, 32'h3);
    // Results hold while comparator moves
    freq_high <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(act(), res1);
    axi_rd(VCA_ADDR_RESULT, rd, rsp);
    chk(rd, res1);
    // Start from current settings
    axi_wr(VCA_ADDR_CTRL, 32'h2, rsp);
    axi_wr(VCA_ADDR_START, pk(3'h5, 8'hC0, 9'h050), rsp);
    axi_wr(VCA_ADDR_CTRL, 32'h3, rsp);
    wait_busy(1'b1);
    chk(act(), res1);
    wait_busy(1'b0);
    axi_rd(VCA_ADDR_RESULT, rd, rsp);
    chk(rd, act());
    chk({31'h0, rd[15:8] > res1[15:8]}, 32'h1);
    chk(rd & 32'h7, 32'h3);
    // All three values forced
    axi_wr(VCA_ADDR_FORCE, pk(3'h6, 8'h22, 9'h1AB), rsp);
    axi_wr(VCA_ADDR_CTRL, 32'h1C, rsp);
    repeat (2) @(posedge sys_clk);
    chk(act(), pk(3'h6, 8'h22, 9'h1AB));
    axi_wr(VCA_ADDR_CTRL, 32'h1D, rsp);
    for (i = 0; i < 30; i++) begin
      @(posedge sys_clk);
      chk(act() | {cal_busy, 31'h0}, pk(3'h6, 8'h22, 9'h1AB));
    end
    // Only core forced, calibration still runs
    axi_wr(VCA_ADDR_CTRL, 32'h5, rsp);
    wait_busy(1'b1);
    chk(act() & 32'h7, 32'h6);
    wait_busy(1'b0);
    axi_rd(VCA_ADDR_STATUS, rd, rsp);
    chk(rd, 32'h2);
    axi_rd(VCA_ADDR_RESULT, rd, rsp);
    chk(rd & 32'h7, 32'h6);
    give_verdict();
  end
endmodule
